/* dac_bank_regs.svh */
`ifndef DAC_BANK_REGS_SVH
`define DAC_BANK_REGS_SVH

// register offsets
`define OFS_STAGE_FIRST   8'h00
`define OFS_STAGE_LAST    8'h0a
`define OFS_BANK_FIRST    8'h10
`define OFS_BANK_LAST     8'h3b
`define OFS_SOFT_SEL      8'h50
`define OFS_STANDBY       8'h51
`define OFS_STATUS        8'h57
`define OFS_CONFIG        8'h60

// field positions
`define FLD_OPCFG_BIT0    0
`define FLD_OPCFG_BIT1    1
`define FLD_STANDBY       0
`define FLD_STAT_LOAD     7
`define FLD_STAT_SEL1     1
`define FLD_STAT_SEL0     0

// reset and delivery values
`define RST_STAGE         8'h00
`define RST_BANK          8'h80
`define RST_SOFT_SEL      2'h0
`define RST_STANDBY       1'h0
`define RST_CONFIG        8'h10

// upper six bits of the 7-bit bus address; low bit follows the pin
`define SLAVE_ADDR_HI     6'h30

// bytes of bank storage per channel
`define BANKS_PER_CH      4

`endif

/* dac_bank_pkg.sv */
package dac_bank_pkg;

    // operating mode decoded from the configuration bits
    typedef enum logic [1:0]
    {
        MODE_PIN_BANK  = 2'h0,
        MODE_SOFT_BANK = 2'h1,
        MODE_DIRECT    = 2'h2
    } op_mode_e;

    // serial slave states, gray coded along the write path
    typedef enum logic [3:0]
    {
        SL_IDLE   = 4'h0,
        SL_ADDR   = 4'h1,
        SL_AACK   = 4'h3,
        SL_PTR    = 4'h2,
        SL_PACK   = 4'h6,
        SL_WDATA  = 4'h7,
        SL_WACK   = 4'h5,
        SL_RDATA  = 4'h4,
        SL_RACK   = 4'hc
    } slave_state_e;

endpackage

/* dac_i2c_slave.sv */
`timescale 1ns/10ps
`include "dac_bank_regs.svh"

// byte-oriented serial slave: address byte, register pointer, data bytes
module dac_i2c_slave
    import dac_bank_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // synchronised bus lines and address pin
    input  wire logic       sclS,
    input  wire logic       sdaS,
    input  wire logic       addrSel,
    // open-drain data drive
    output logic            sdaOut,
    output logic            sdaOe,
    // register side
    output logic            wrEn,
    output logic [7:0]      regAddr,
    output logic [7:0]      wrData,
    input  wire logic [7:0] rdData
);

    slave_state_e state_r;
    logic       sclPrev;
    logic       sdaPrev;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] bitCnt_r;
    logic       readDir_r;
    logic       masterAck_r;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic [6:0] myAddr;

    // edge and condition detection on synchronised lines
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    assign sclRise   = sclS && !sclPrev;
    assign sclFall   = !sclS && sclPrev;
    assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
    assign stopCond  = sclS && sclPrev && !sdaPrev && sdaS;
    assign myAddr    = {`SLAVE_ADDR_HI, addrSel};

    // protocol sequencer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_r     <= SL_IDLE;
            sdaOut      <= 1'b0;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            bitCnt_r    <= 4'h0;
            readDir_r   <= 1'b0;
            masterAck_r <= 1'b0;
            sdaOe       <= 1'b0;
            wrEn        <= 1'b0;
            regAddr     <= 8'h00;
            wrData      <= 8'h00;
        end
        else
        begin
            wrEn <= 1'b0;
            // open drain: the data pin is only ever pulled low
            sdaOut <= 1'b0;
            if (startCond)
            begin
                state_r  <= SL_ADDR;
                bitCnt_r <= 4'h0;
                sdaOe    <= 1'b0;
            end
            else if (stopCond)
            begin
                state_r <= SL_IDLE;
                sdaOe   <= 1'b0;
            end
            else if (sclRise)
            begin
                case (state_r)
                    SL_ADDR, SL_PTR, SL_WDATA:
                    begin
                        shift_r  <= {shift_r[6:0], sdaS};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                    SL_RDATA:
                        bitCnt_r <= bitCnt_r + 4'h1;
                    SL_RACK:
                        masterAck_r <= !sdaS;
                    default:
                        state_r <= state_r;
                endcase
            end
            else if (sclFall)
            begin
                case (state_r)
                    SL_ADDR:
                        if (bitCnt_r == 4'h8)
                        begin
                            // 7-bit address then direction bit
                            if (shift_r[7:1] == myAddr)
                            begin
                                state_r   <= SL_AACK;
                                readDir_r <= shift_r[0];
                                sdaOe     <= 1'b1;
                            end
                            else
                                state_r <= SL_IDLE;
                        end
                    SL_AACK:
                    begin
                        bitCnt_r <= 4'h0;
                        if (readDir_r)
                        begin
                            state_r <= SL_RDATA;
                            tx_r    <= rdData;
                            sdaOe   <= !rdData[7];
                        end
                        else
                        begin
                            state_r <= SL_PTR;
                            sdaOe   <= 1'b0;
                        end
                    end
                    SL_PTR:
                        if (bitCnt_r == 4'h8)
                        begin
                            regAddr <= shift_r;
                            state_r <= SL_PACK;
                            sdaOe   <= 1'b1;
                        end
                    SL_PACK, SL_WACK:
                    begin
                        state_r  <= SL_WDATA;
                        bitCnt_r <= 4'h0;
                        sdaOe    <= 1'b0;
                    end
                    SL_WDATA:
                        if (bitCnt_r == 4'h8)
                        begin
                            wrEn    <= 1'b1;
                            wrData  <= shift_r;
                            state_r <= SL_WACK;
                            sdaOe   <= 1'b1;
                        end
                    SL_RDATA:
                        if (bitCnt_r == 4'h8)
                        begin
                            state_r <= SL_RACK;
                            sdaOe   <= 1'b0;
                            regAddr <= regAddr + 8'h01;
                        end
                        else
                        begin
                            tx_r  <= {tx_r[6:0], 1'b0};
                            sdaOe <= !tx_r[6];
                        end
                    SL_RACK:
                        if (masterAck_r)
                        begin
                            state_r  <= SL_RDATA;
                            bitCnt_r <= 4'h0;
                            tx_r     <= rdData;
                            sdaOe    <= !rdData[7];
                        end
                        else
                            state_r <= SL_IDLE;
                    default:
                        state_r <= SL_IDLE;
                endcase
            end
            // pointer advances once the written byte has been taken
            if (wrEn)
                regAddr <= regAddr + 8'h01;
        end
    end

endmodule

/* dac_bank_update_control.sv */
`timescale 1ns/10ps
`include "dac_bank_regs.svh"

module dac_bank_update_control
    import dac_bank_pkg::*;
#(
    parameter int NUM_CH = 11
)
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // serial bus pins
    input  wire logic                  scl,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    // control pins
    input  wire logic                  addr_select_pin,
    input  wire logic                  load_strobe,
    input  wire logic                  bank_sel_pin0,
    input  wire logic                  bank_sel_pin1,
    input  wire logic                  overTemp,
    // dac codes, channel 0 common, 1..10 gamma
    output logic [NUM_CH-1:0][7:0]     dacCode,
    // analog buffer enables
    output logic                       commonOutEn,
    output logic                       gammaOutEn
);

    localparam int BANK_BYTES = NUM_CH * `BANKS_PER_CH;

    // elaboration check: the map holds exactly eleven channels
    generate
        if (NUM_CH != 11)
        begin : g_chk
            $error("NUM_CH must be 11");
        end
    endgenerate

    logic [6:0] syncA_r;
    logic [6:0] syncB_r;
    logic       sclS;
    logic       sdaS;
    logic       addrS;
    logic       loadS;
    logic       sel0S;
    logic       sel1S;
    logic       hotS;
    logic       loadPrev_r;
    logic       latchOpen;

    logic [7:0] stage_r [NUM_CH];
    logic [7:0] bank_r [BANK_BYTES];
    logic [1:0] softSel_r;
    logic       standby_r;
    logic [7:0] config_r;

    logic       wrEn;
    logic [7:0] regAddr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic [7:0] bankIdx;
    op_mode_e   mode;
    logic [1:0] bankSel;

    // two-stage synchronisers for every pin
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            syncA_r <= 7'h03;
            syncB_r <= 7'h03;
        end
        else
        begin
            syncA_r <= {overTemp, bank_sel_pin1, bank_sel_pin0,
                        load_strobe, addr_select_pin, sdaIn, scl};
            syncB_r <= syncA_r;
        end
    end

    assign sclS  = syncB_r[0];
    assign sdaS  = syncB_r[1];
    assign addrS = syncB_r[2];
    assign loadS = syncB_r[3];
    assign sel0S = syncB_r[4];
    assign sel1S = syncB_r[5];
    assign hotS  = syncB_r[6];

    // serial slave, independent of standby
    dac_i2c_slave u_slave
    (
        .mclk    (mclk),
        .rst     (rst),
        .sclS    (sclS),
        .sdaS    (sdaS),
        .addrSel (addrS),
        .sdaOut  (sdaOut),
        .sdaOe   (sdaOe),
        .wrEn    (wrEn),
        .regAddr (regAddr),
        .wrData  (wrData),
        .rdData  (rdData)
    );

    // mode decode from configuration bits
    always_comb
    begin
        if (config_r[`FLD_OPCFG_BIT1])
            mode = MODE_DIRECT;
        else if (config_r[`FLD_OPCFG_BIT0])
            mode = MODE_SOFT_BANK;
        else
            mode = MODE_PIN_BANK;
    end

    // bank source: pins or software bits, high bit first
    assign bankSel = (mode == MODE_SOFT_BANK) ? softSel_r
                                              : {sel1S, sel0S};

    // staging registers, written only at their own addresses
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_CH; i++)
                stage_r[i] <= `RST_STAGE;
        end
        else if (wrEn && regAddr <= `OFS_STAGE_LAST)
        begin
            stage_r[regAddr[3:0]] <= wrData;
        end
    end

    // bank storage, four bytes per channel
    assign bankIdx = regAddr - `OFS_BANK_FIRST;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < BANK_BYTES; i++)
                bank_r[i] <= `RST_BANK;
        end
        else if (wrEn && regAddr >= `OFS_BANK_FIRST
                 && regAddr <= `OFS_BANK_LAST)
        begin
            bank_r[bankIdx[5:0]] <= wrData;
        end
    end

    // control registers; reserved addresses fall through
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            softSel_r <= `RST_SOFT_SEL;
            standby_r <= `RST_STANDBY;
            config_r  <= `RST_CONFIG;
        end
        else if (wrEn)
        begin
            if (regAddr == `OFS_SOFT_SEL)
                softSel_r <= wrData[1:0];
            else if (regAddr == `OFS_STANDBY)
                standby_r <= wrData[`FLD_STANDBY];
            else if (regAddr == `OFS_CONFIG)
                config_r <= wrData;
        end
    end

    // read decode; status shows live pins
    always_comb
    begin
        rdData = 8'h00;
        if (regAddr <= `OFS_STAGE_LAST)
            rdData = stage_r[regAddr[3:0]];
        else if (regAddr >= `OFS_BANK_FIRST && regAddr <= `OFS_BANK_LAST)
            rdData = bank_r[bankIdx[5:0]];
        else if (regAddr == `OFS_SOFT_SEL)
            rdData = {6'h00, softSel_r};
        else if (regAddr == `OFS_STANDBY)
            rdData = {7'h00, standby_r};
        else if (regAddr == `OFS_STATUS)
        begin
            rdData[`FLD_STAT_LOAD] = loadS;
            rdData[`FLD_STAT_SEL1] = sel1S;
            rdData[`FLD_STAT_SEL0] = sel0S;
        end
        else if (regAddr == `OFS_CONFIG)
            rdData = config_r;
    end

    // strobe history for the falling-edge capture
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            loadPrev_r <= 1'b0;
        else
            loadPrev_r <= loadS;
    end

    // open while high, including its rising edge; the falling-edge cycle
    // takes one last sample and then holds
    assign latchOpen = loadS || loadPrev_r;

    // output latch per channel; codes go to the dacs unaltered
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    dacCode[ch] <= `RST_BANK;
                else if (latchOpen)
                begin
                    if (mode == MODE_DIRECT)
                        dacCode[ch] <= stage_r[ch];
                    else
                        dacCode[ch] <= bank_r[ch * `BANKS_PER_CH
                                              + int'(bankSel)];
                end
            end
        end
    endgenerate

    // buffer enables: standby drops all, heat drops the common one
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            commonOutEn <= 1'b0;
            gammaOutEn  <= 1'b0;
        end
        else
        begin
            commonOutEn <= !standby_r && !hotS;
            gammaOutEn  <= !standby_r;
        end
    end

endmodule

/* dac_bank_assertions.sv */
`timescale 1ns/10ps
// pin-level checks on the bank update control block
module dac_bank_assertions
#(
    parameter int NUM_CH = 11
)
(
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst,
    // serial bus pins
    input wire logic                   scl,
    input wire logic                   sdaIn,
    input wire logic                   sdaOut,
    input wire logic                   sdaOe,
    // control pins
    input wire logic                   addr_select_pin,
    input wire logic                   load_strobe,
    input wire logic                   bank_sel_pin0,
    input wire logic                   bank_sel_pin1,
    input wire logic                   overTemp,
    // codes and buffer enables
    input wire logic [NUM_CH-1:0][7:0] dacCode,
    input wire logic                   commonOutEn,
    input wire logic                   gammaOutEn
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // strobe low long enough for the capture to have landed
    sequence strobeLow;
        (!load_strobe)[*6];
    endsequence

    // temperature indication steady past its synchroniser
    sequence hotSteady;
        overTemp[*6];
    endsequence
    sequence coolSteady;
        (!overTemp)[*6];
    endsequence

    hold_code_a: assert property (strobeLow |=> $stable(dacCode))
        else $error("codes moved while strobe held low");
    change_cause_a: assert property ($changed(dacCode) |->
        $past(load_strobe, 2) || $past(load_strobe, 3) ||
        $past(load_strobe, 4) || $past(load_strobe, 5))
        else $error("codes moved without a recent strobe");
    hot_off_a: assert property (hotSteady |-> !commonOutEn)
        else $error("common buffer on while too hot");
    cool_on_a: assert property (coolSteady ##0 gammaOutEn |-> commonOutEn)
        else $error("common buffer off while cool and awake");
    standby_pair_a: assert property (!gammaOutEn |-> !commonOutEn)
        else $error("gamma off but common still driven");
    ack_timing_a: assert property ($rose(sdaOe) |-> !scl &&
        ($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
        else $error("data drive began outside the clock low phase");
    ack_stable_a: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("data drive changed while clock high");
    open_drain_a: assert property (sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
endmodule

/* dac_bus_master.sv */
`timescale 1ns/10ps
// serial bus master model; data line only ever pulled low or released
module dac_bus_master
(
    // clock and wire level
    input  wire logic mclk,
    input  wire logic sdaLine,
    // master drive
    output logic      scl,
    output logic      sdaLow
);
    // each clock phase 6 cycles, room for the slave's 3-cycle answer
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // step a number of edges, then settle just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    // one clock pulse, data changed only while clock low
    task automatic bitCycle(input logic drv, output logic seen);
        tick(1);
        sdaLow = !drv;
        tick(5);
        scl = 1'b1;
        tick(3);
        seen = sdaLine;
        tick(3);
        scl = 1'b0;
    endtask

    // start or repeated start, and stop
    task automatic start();
        tick(1);
        sdaLow = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(6);
        sdaLow = 1'b1;
        tick(6);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(1);
        sdaLow = 1'b1;
        tick(6);
        scl = 1'b1;
        tick(6);
        sdaLow = 1'b0;
        tick(6);
    endtask

    // byte out msb first, then the slave's acknowledge
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitCycle(b[i], s);
        bitCycle(1'b1, s);
        ack = !s;
    endtask

    // write: address byte, pointer, then data bytes in turn
    task automatic writeRegs(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] data[$], output logic ack);
        logic a;
        start();
        sendByte({dev, 1'b0}, ack);
        if (ack)
        begin
            sendByte(ptr, a);
            foreach (data[i])
                sendByte(data[i], a);
        end
        stop();
    endtask

    // read one byte at a pointer; not acknowledged, ends the read
    task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [7:0] val);
        logic a;
        start();
        sendByte({dev, 1'b0}, a);
        sendByte(ptr, a);
        start();
        sendByte({dev, 1'b1}, a);
        for (int i = 7; i >= 0; i--)
            bitCycle(1'b1, val[i]);
        bitCycle(1'b1, a);
        stop();
    endtask
endmodule

/* dac_bank_update_control_tb_top.sv */
`timescale 1ns/10ps
`define CMP(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("Error at %0t: want %h got %h", $time, a, b); \
        end \
    end

// bench: serial writes and reads, pins and strobe driven off the edge
module dac_bank_update_control_tb_top;
    localparam logic [6:0] DEV = 7'h60;
    localparam logic [7:0] RA [6] = '{8'h00, 8'h10, 8'h50, 8'h51, 8'h60, 8'h0b};
    localparam logic [7:0] RV [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h10, 8'h00};
    logic              mclk, rst, scl, sdaLow, sdaLine, sdaOut, sdaOe;
    logic              addrPin, strobe, pin0, pin1, hot, ack;
    logic              commonEn, gammaEn;
    logic [10:0][7:0]  dacCode;
    logic [7:0]        bankMem [44];
    logic [7:0]        stage [11];
    logic [7:0]        expQ[$], gotQ[$], e, g, v;
    logic [7:0]        q[$];
    int                mismatches, compares, cycles;

    // open-drain data line with pull-up
    assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));

    dac_bank_update_control u_dac_bank_update_control (
        .mclk(mclk), .rst(rst), .scl(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_pin(addrPin),
        .load_strobe(strobe), .bank_sel_pin0(pin0), .bank_sel_pin1(pin1),
        .overTemp(hot), .dacCode(dacCode), .commonOutEn(commonEn),
        .gammaOutEn(gammaEn));
    dac_bus_master u_dac_bus_master (
        .mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

    // clock and cycle limit
    always #50 mclk = !mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // compare each observed result against the oldest expectation
    always @(posedge mclk)
    begin
        while (gotQ.size() > 0)
        begin
            e = expQ.pop_front();
            g = gotQ.pop_front();
            `CMP(e, g)
        end
    end

    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        expQ.push_back(exp);
        gotQ.push_back(got);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] dq[$];
        dq.push_back(d);
        u_dac_bus_master.writeRegs(DEV, ptr, dq, ack);
    endtask
    task automatic rdChk(input logic [7:0] ptr, input logic [7:0] exp);
        u_dac_bus_master.readReg(DEV, ptr, v);
        check(exp, v);
    endtask
    // sel 0..3 expects that bank on every channel, 4 the staging bytes
    task automatic dacChk(input int sel);
        u_dac_bus_master.tick(8);
        for (int c = 0; c < 11; c++)
            check(sel < 4 ? bankMem[c * 4 + sel] : stage[c], dacCode[c]);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {mclk, rst, addrPin, strobe, pin0, pin1, hot} = 7'b0100000;
        foreach (bankMem[i])
            bankMem[i] = 8'h80;
        foreach (stage[i])
            stage[i] = 8'h00;
        void'($urandom(62));
        repeat (12) @(posedge mclk);
        #5 rst = 1'b0;
        u_dac_bus_master.tick(4);
        dacChk(0);
        foreach (RA[i])
            rdChk(RA[i], RV[i]);
        wr(8'h0c, 8'h5a);
        rdChk(8'h0c, 8'h00);
        for (int i = 0; i < 44; i++)
        begin
            bankMem[i] = 8'($urandom);
            q.push_back(bankMem[i]);
        end
        u_dac_bus_master.writeRegs(DEV, 8'h10, q, ack);
        rdChk(8'h3b, bankMem[43]);
        strobe = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            {pin1, pin0} = 2'(s);
            dacChk(s);
        end
        strobe = 1'b0;
        u_dac_bus_master.tick(6);
        {pin1, pin0} = 2'h1;
        dacChk(3);
        rdChk(8'h57, 8'h01);
        strobe = 1'b1;
        dacChk(1);
        rdChk(8'h57, 8'h81);
        wr(8'h60, 8'h01);
        dacChk(0);
        for (int s = 3; s >= 0; s--)
        begin
            wr(8'h50, 8'(s));
            dacChk(s);
        end
        wr(8'h60, 8'h02);
        stage[3] = 8'($urandom);
        wr(8'h03, stage[3]);
        dacChk(4);
        wr(8'h60, 8'h03);
        strobe = 1'b0;
        v = 8'($urandom);
        wr(8'h05, v);
        dacChk(4);
        stage[5] = v;
        strobe = 1'b1;
        dacChk(4);
        wr(8'h51, 8'h01);
        check(8'h00, {7'h0, commonEn});
        check(8'h00, {7'h0, gammaEn});
        rdChk(8'h05, stage[5]);
        wr(8'h51, 8'h00);
        hot = 1'b1;
        u_dac_bus_master.tick(8);
        check(8'h00, {7'h0, commonEn});
        check(8'h01, {7'h0, gammaEn});
        v = 8'($urandom);
        hot = v[0];
        u_dac_bus_master.tick(8);
        check({7'h0, !v[0]}, {7'h0, commonEn});
        hot = 1'b0;
        u_dac_bus_master.tick(8);
        check(8'h01, {7'h0, commonEn});
        // both address pin levels, in random order
        for (int k = 0; k < 2; k++)
        begin
            addrPin = v[1] ^ k[0];
            u_dac_bus_master.writeRegs({6'h30, !addrPin}, 8'h51, q, ack);
            check(8'h00, {7'h0, ack});
            u_dac_bus_master.writeRegs({6'h30, addrPin}, 8'h0b, q, ack);
            check(8'h01, {7'h0, ack});
        end
        addrPin = 1'b0;
        wr(8'h50, 8'h03);
        rst = 1'b1;
        u_dac_bus_master.tick(2);
        rst = 1'b0;
        u_dac_bus_master.tick(4);
        rdChk(8'h50, 8'h00);
        u_dac_bus_master.tick(2);
        tally_and_finish();
    end
endmodule

bind dac_bank_update_control dac_bank_assertions #(.NUM_CH(NUM_CH)) u_chk (
    .mclk(mclk), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addr_select_pin(addr_select_pin),
    .load_strobe(load_strobe), .bank_sel_pin0(bank_sel_pin0),
    .bank_sel_pin1(bank_sel_pin1), .overTemp(overTemp), .dacCode(dacCode),
    .commonOutEn(commonOutEn), .gammaOutEn(gammaOutEn));
